/* pkg/ppr_pkg.sv */
// Constants and types shared by the paged register file.
package ppr_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] PPR_IDX_NODE   = 4'h0;
  localparam logic [3:0] PPR_IDX_GAP    = 4'h1;
  localparam logic [3:0] PPR_IDX_EXT    = 4'h2;
  localparam logic [3:0] PPR_IDX_SPEED  = 4'h3;
  localparam logic [3:0] PPR_IDX_LINK   = 4'h4;
  localparam logic [3:0] PPR_IDX_FEAT   = 4'h5;
  localparam logic [3:0] PPR_IDX_LEGACY = 4'h6;
  localparam logic [3:0] PPR_IDX_PAGE   = 4'h7;
  localparam logic [3:0] PPR_IDX_PAGED0 = 4'h8;
  localparam int         PPR_ADDR_SHIFT = 2;

  // Field positions (bit index of the field's least significant bit).
  localparam int PPR_NODE_POS   = 2;
  localparam int PPR_ROOT_POS   = 1;
  localparam int PPR_CABLE_POS  = 0;
  localparam int PPR_HOLD_POS   = 7;
  localparam int PPR_LONG_POS   = 6;
  localparam int PPR_EXT_POS    = 5;
  localparam int PPR_SPEED_POS  = 5;
  localparam int PPR_STBY_POS   = 4;
  localparam int PPR_LACT_POS   = 7;
  localparam int PPR_CONT_POS   = 6;
  localparam int PPR_JITTER_POS = 3;
  localparam int PPR_LEGACY_POS = 5;
  localparam int PPR_BETA_POS   = 4;
  localparam int PPR_BRIDGE_POS = 2;
  localparam int PPR_PAGE_POS   = 5;

  // Constant field values and reset values.
  localparam logic [2:0] PPR_EXT_CODE     = 3'h7;
  localparam logic [3:0] PPR_PORT_COUNT   = 4'h3;
  localparam logic [2:0] PPR_SPEED_CODE   = 3'h7;
  localparam logic [3:0] PPR_DELAY_CODE   = 4'hF;
  localparam logic [2:0] PPR_JITTER_CODE  = 3'h0;
  localparam logic [5:0] PPR_GAP_RESET    = 6'h3F;
  localparam logic [7:0] PPR_FEAT_RESET   = 8'h00;
  localparam logic [2:0] PPR_PWR_RESET    = 3'h0;
  localparam logic [2:0] PPR_PAGE_RESET   = 3'h0;
  localparam logic [3:0] PPR_PORT_RESET   = 4'h0;
  localparam logic [2:0] PPR_PAGE_RSV_LO  = 3'h2;
  localparam logic [2:0] PPR_PAGE_RSV_HI  = 3'h6;
  localparam logic [2:0] PPR_PAGE_TOP     = 3'h7;

  // Long bus reset duration.
  localparam int PPR_CLK_PERIOD_NS  = 40;
  localparam int PPR_LONG_RESET_NS  = 166000;
  localparam int PPR_LONG_RESET_CYC = PPR_LONG_RESET_NS / PPR_CLK_PERIOD_NS;

  // Long bus reset sequencer states, one-hot.
  typedef enum logic [2:0] {
    PPR_LR_IDLE  = 3'b001,
    PPR_LR_WAIT  = 3'b010,
    PPR_LR_DRIVE = 3'b100
  } ppr_lr_type;

  // Entire state of the register file.
  typedef struct packed {
    logic                 root;
    logic                 rootHoldoff;
    logic                 longReq;
    logic [5:0]           gap;
    logic                 seenReset;
    logic                 standbyOk;
    logic                 linkActive;
    logic                 contender;
    logic [2:0]           pwrClass;
    logic [7:0]           feat;
    logic [1:0]           bridge;
    logic [2:0]           page;
    logic [3:0]           port;
    logic [2:0][7:0][7:0] paged;
    ppr_lr_type           lrState;
    logic [15:0]          lrCount;
    logic [7:0]           rdata;
  } ppr_state_type;
endpackage : ppr_pkg

/* hw/paged_phy_register_file.sv */
// Paged register file of the serial bus physical layer, reached over APB.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: Sixteen byte registers, indices 0h to Fh, reachable from the link side.
// R2: Indices 0h to 7h are the base set, same layout on every page.
// R3: Indices 8h to Fh decode against the selected page, one of eight.
// R4: The page comes from the page field of base register 7h, beside port select.
// R5: Reserved registers and fields read as zero.
// R6: On pages 2 to 6 every paged location is reserved.
// R7: Constant fields read their fixed codes: 111b, 0011b, 111b, 1111b, 000b.
// R8: Root flag clears on each bus reset, sets when tree identification makes us root.
// R9: Writing one requests a long bus reset after traffic; bit clears on any reset.
// R10: Gap count returns to 3Fh on hardware reset or two resets without update.
module paged_phy_register_file
  import ppr_pkg::*;
#(
  parameter int LONG_RESET_CYCLES = PPR_LONG_RESET_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  nodeNumber,
  input  wire logic        cablePowerOk,
  input  wire logic        treeIdRoot,
  input  wire logic        busResetSeen,
  input  wire logic        configGapLoad,
  input  wire logic [5:0]  configGapValue,
  input  wire logic        trafficIdle,
  input  wire logic [2:0]  topLegacyRate,
  input  wire logic        betaLinkFlag,
  output logic             longResetActive,
  output logic             rootHoldoffFlag,
  output logic      [5:0]  gapCount,
  output logic             standbyRestoreAllow,
  output logic             linkActiveFlag,
  output logic             contenderFlag,
  output logic      [2:0]  powerClass,
  output logic      [7:0]  featureEnables,
  output logic      [2:0]  pageSelect,
  output logic      [3:0]  portSelect
);

  localparam logic [15:0] LR_LOAD = 16'(LONG_RESET_CYCLES - 1);

  // Register index of an APB byte address.
  function automatic logic [3:0] regIndex(input logic [7:0] addr);
    return addr[PPR_ADDR_SHIFT +: 4];
  endfunction : regIndex

  // True when the address hits one of the sixteen aligned words.
  function automatic logic addrMapped(input logic [7:0] addr);
    return (addr[7:6] == 2'h0) && (addr[1:0] == 2'h0);
  endfunction : addrMapped

  // Storage slot of a page; slot 3 means the page has no storage.
  function automatic logic [1:0] pageSlot(input logic [2:0] page);
    logic [1:0] slot;
    slot = 2'h3;
    if (page == 3'h0) begin
      slot = 2'h0;
    end else if (page == 3'h1) begin
      slot = 2'h1;
    end else if (page == PPR_PAGE_TOP) begin
      slot = 2'h2;
    end
    return slot;
  endfunction : pageSlot

  ppr_state_type stReg;
  ppr_state_type stNext;
  logic          setupRd;
  logic          accessWr;
  logic [3:0]    wIdx;
  logic [7:0]    wByte;
  logic [7:0]    rdByte;
  logic          busEvent;
  logic          gapWrite;

  // APB decode; the slave never inserts wait states.
  assign setupRd  = psel && !penable && !pwrite;
  assign accessWr = psel && penable && pwrite && addrMapped(paddr);
  assign wIdx     = regIndex(paddr); // R1
  assign wByte    = pwdata[7:0];
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !addrMapped(paddr);
  assign gapWrite = configGapLoad || (accessWr && wIdx == PPR_IDX_GAP);
  // A bus reset is one seen on the bus or the one this block launches.
  assign busEvent = busResetSeen || ((stReg.lrState == PPR_LR_WAIT) && trafficIdle);

  // Read mux: every bit not listed below is reserved and reads as zero.
  always_comb begin
    rdByte = 8'h00; // R5
    case (regIndex(paddr))
      PPR_IDX_NODE: begin
        rdByte[PPR_NODE_POS +: 6] = nodeNumber;
        rdByte[PPR_ROOT_POS]      = stReg.root;
        rdByte[PPR_CABLE_POS]     = cablePowerOk;
      end
      PPR_IDX_GAP: begin
        rdByte = {stReg.rootHoldoff, stReg.longReq, stReg.gap};
      end
      PPR_IDX_EXT: begin
        rdByte[PPR_EXT_POS +: 3] = PPR_EXT_CODE; // R7
        rdByte[3:0]              = PPR_PORT_COUNT; // R7
      end
      PPR_IDX_SPEED: begin
        rdByte[PPR_SPEED_POS +: 3] = PPR_SPEED_CODE; // R7
        rdByte[PPR_STBY_POS]       = stReg.standbyOk;
        rdByte[3:0]                = PPR_DELAY_CODE; // R7
      end
      PPR_IDX_LINK: begin
        rdByte[PPR_LACT_POS]          = stReg.linkActive;
        rdByte[PPR_CONT_POS]          = stReg.contender;
        rdByte[PPR_JITTER_POS +: 3]   = PPR_JITTER_CODE; // R7
        rdByte[2:0]                   = stReg.pwrClass;
      end
      PPR_IDX_FEAT: begin
        rdByte = stReg.feat;
      end
      PPR_IDX_LEGACY: begin
        rdByte[PPR_LEGACY_POS +: 3]  = topLegacyRate;
        rdByte[PPR_BETA_POS]         = betaLinkFlag;
        rdByte[PPR_BRIDGE_POS +: 2]  = stReg.bridge;
      end
      PPR_IDX_PAGE: begin
        rdByte[PPR_PAGE_POS +: 3] = stReg.page; // R4
        rdByte[3:0]               = stReg.port;
      end
      default: begin
        // Paged window: pages 2 to 6 have no storage and read zero.
        if (pageSlot(stReg.page) != 2'h3) begin // R3 R6
          rdByte = stReg.paged[pageSlot(stReg.page)][wIdx[2:0]];
        end
      end
    endcase
    if (!addrMapped(paddr)) begin
      rdByte = 8'h00;
    end
  end

  // Next-state logic for the whole register file.
  always_comb begin
    stNext = stReg;
    if (setupRd) begin
      stNext.rdata = rdByte;
    end
    // Software writes; base layout does not depend on the page.
    if (accessWr) begin // R2
      case (wIdx)
        PPR_IDX_GAP: begin
          stNext.rootHoldoff = wByte[PPR_HOLD_POS];
          stNext.longReq     = wByte[PPR_LONG_POS] || stReg.longReq;
          stNext.gap         = wByte[5:0];
        end
        PPR_IDX_SPEED: begin
          stNext.standbyOk = wByte[PPR_STBY_POS];
        end
        PPR_IDX_LINK: begin
          stNext.linkActive = wByte[PPR_LACT_POS];
          stNext.contender = wByte[PPR_CONT_POS];
          stNext.pwrClass  = wByte[2:0];
        end
        PPR_IDX_FEAT: begin
          stNext.feat = wByte;
        end
        PPR_IDX_LEGACY: begin
          stNext.bridge = wByte[PPR_BRIDGE_POS +: 2];
        end
        PPR_IDX_PAGE: begin
          stNext.page = wByte[PPR_PAGE_POS +: 3]; // R4
          stNext.port = wByte[3:0];
        end
        PPR_IDX_NODE, PPR_IDX_EXT: begin
          stNext.rdata = stReg.rdata;
        end
        default: begin
          // Writes to reserved pages are dropped.
          if (pageSlot(stReg.page) != 2'h3) begin // R3 R6
            stNext.paged[pageSlot(stReg.page)][wIdx[2:0]] = wByte;
          end
        end
      endcase
    end
    // Long bus reset sequencer: wait for traffic to finish, then drive.
    case (stReg.lrState)
      PPR_LR_IDLE: begin
        if (stReg.longReq) begin
          stNext.lrState = PPR_LR_WAIT; // R9
        end
      end
      PPR_LR_WAIT: begin
        if (trafficIdle) begin
          stNext.lrState = PPR_LR_DRIVE; // R9
          stNext.lrCount = LR_LOAD;
        end
      end
      PPR_LR_DRIVE: begin
        if (stReg.lrCount == 16'h0000) begin
          stNext.lrState = PPR_LR_IDLE;
        end else begin
          stNext.lrCount = stReg.lrCount - 16'h0001;
        end
      end
      default: begin
        stNext.lrState = PPR_LR_IDLE;
      end
    endcase
    // Request bit clears on a bus reset unless a new one is written now.
    if (busEvent && !(accessWr && wIdx == PPR_IDX_GAP && wByte[PPR_LONG_POS])) begin
      stNext.longReq = 1'b0; // R9
    end
    // Root flag: setting by tree identification wins over the clear.
    if (treeIdRoot) begin
      stNext.root = 1'b1; // R8
    end else if (busEvent) begin
      stNext.root = 1'b0; // R8
    end
    // Gap count: any update restarts the two-reset watch.
    if (gapWrite) begin
      if (configGapLoad) begin
        stNext.gap = configGapValue;
      end
      stNext.seenReset = busEvent;
    end else if (busEvent) begin
      if (stReg.seenReset) begin
        stNext.gap = PPR_GAP_RESET; // R10
      end
      stNext.seenReset = 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      stReg             <= '0;
      stReg.gap         <= PPR_GAP_RESET; // R10
      stReg.feat        <= PPR_FEAT_RESET;
      stReg.pwrClass    <= PPR_PWR_RESET;
      stReg.page        <= PPR_PAGE_RESET;
      stReg.port        <= PPR_PORT_RESET;
      stReg.lrState     <= PPR_LR_IDLE;
    end else begin
      stReg <= stNext;
    end
  end

  // Outputs straight from the state register.
  assign prdata              = {24'h000000, stReg.rdata}; // R5
  assign longResetActive     = (stReg.lrState == PPR_LR_DRIVE);
  assign rootHoldoffFlag     = stReg.rootHoldoff;
  assign gapCount            = stReg.gap;
  assign standbyRestoreAllow = stReg.standbyOk;
  assign linkActiveFlag      = stReg.linkActive;
  assign contenderFlag       = stReg.contender;
  assign powerClass          = stReg.pwrClass;
  assign featureEnables      = stReg.feat;
  assign pageSelect          = stReg.page;
  assign portSelect          = stReg.port;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [15:0] activeLen;
  // Counts the cycles the long reset has been driven.
  always_ff @(posedge clk) begin
    if (srst || !longResetActive) begin
      activeLen <= 16'h0000;
    end else begin
      activeLen <= activeLen + 16'h0001;
    end
  end

  sequence longReqWrite;
    accessWr && wIdx == PPR_IDX_GAP && wByte[PPR_LONG_POS] && !busEvent;
  endsequence
  sequence trafficDone;
    trafficIdle [*2];
  endsequence

  a_apb_ready: assert property (psel && penable |-> pready && !$past(pready)) // R1
    else $error("pready not a single access cycle");
  a_unmapped_err: assert property (psel && penable && !addrMapped(paddr) |-> pslverr) // R1
    else $error("unmapped address gave no error");
  a_upper_zero: assert property (prdata[31:8] == 24'h000000) // R5
    else $error("upper read data not zero");
  a_const_read: assert property (setupRd && addrMapped(paddr) && regIndex(paddr) == PPR_IDX_EXT
    |=> prdata[7:0] == 8'hE3) // R7
    else $error("constant register misread");
  a_reserved_page: assert property (setupRd && addrMapped(paddr) && paddr[5]
    && stReg.page >= PPR_PAGE_RSV_LO && stReg.page <= PPR_PAGE_RSV_HI |=> prdata == 32'h0) // R6
    else $error("reserved page read nonzero");
  a_page_field: assert property (accessWr && wIdx == PPR_IDX_PAGE |=> pageSelect == $past(wByte[7:5])) // R4
    else $error("page select not taken from register 7");
  a_root_flag: assert property (busResetSeen && !treeIdRoot |=> !stReg.root ##0
    (stReg.root == $past(treeIdRoot))) // R8
    else $error("root flag not cleared by bus reset");
  a_long_start: assert property (longReqWrite ##1 (stReg.lrState == PPR_LR_IDLE) ##0 trafficDone
    |-> ##[1:2] longResetActive) // R9
    else $error("long bus reset not started");
  a_long_length: assert property ($fell(longResetActive) |-> $past(activeLen) == LR_LOAD) // R9
    else $error("long bus reset length wrong");
  a_gap_two: assert property (stReg.seenReset && busEvent && !gapWrite |=> gapCount == 6'h3F) // R10
    else $error("gap count not restored after two resets");
  a_gap_base: assert property (accessWr && wIdx == PPR_IDX_GAP && !configGapLoad
    |=> gapCount == $past(wByte[5:0])) // R2
    else $error("gap count write lost");

endmodule : paged_phy_register_file
`default_nettype wire

/* test/ppr_link_model.sv */
// Link-side APB master that issues the register reads and writes.
`timescale 1ns/100ps
`default_nettype none

module ppr_link_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // The bus is idle from time zero.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One setup and access transfer, held until ready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                      output logic [31:0] rdata, output logic err);
    int waitCnt;
    waitCnt = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h000000, wdata};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      waitCnt++;
    end while (pready !== 1'b1 && waitCnt < 16);
    rdata = prdata;
    err   = pslverr;
    if (pready !== 1'b1) begin
      tb_top.errCount++;
      tb_top.endSim();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines carry no stale request.
    paddr   <= ~addr;
    pwdata  <= ~{24'h000000, wdata};
  endtask : xfer
endmodule : ppr_link_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking testbench for the paged register file.
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import ppr_pkg::*;
;
  localparam int LrCyc = 20;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, cablePowerOk;
  logic        treeIdRoot, busResetSeen, configGapLoad, trafficIdle, betaLinkFlag;
  logic        longResetActive, rootHoldoffFlag, standbyRestoreAllow, linkActiveFlag;
  logic        contenderFlag;
  logic [7:0]  paddr, featureEnables;
  logic [31:0] pwdata, prdata;
  logic [5:0]  nodeNumber, configGapValue, gapCount;
  logic [2:0]  topLegacyRate, powerClass, pageSelect;
  logic [3:0]  portSelect;
  int          errCount, nTests;

  paged_phy_register_file #(.LONG_RESET_CYCLES(LrCyc)) i_paged_phy_register_file (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nodeNumber, .cablePowerOk, .treeIdRoot, .busResetSeen, .configGapLoad,
    .configGapValue, .trafficIdle, .topLegacyRate, .betaLinkFlag, .longResetActive,
    .rootHoldoffFlag, .gapCount, .standbyRestoreAllow, .linkActiveFlag, .contenderFlag,
    .powerClass, .featureEnables, .pageSelect, .portSelect
  );
  ppr_link_model u_link (
    .clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );

  // Clock of 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Register access helpers by index.
  task automatic wr(input logic [3:0] idx, input logic [7:0] val);
    logic [31:0] d;
    logic        e;
    u_link.xfer(1'b1, {2'b00, idx, 2'b00}, val, d, e);
  endtask : wr

  task automatic rdChk(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic        e;
    u_link.xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00, d, e);
    check({7'h00, e, d}, {8'h00, 24'h000000, exp});
  endtask : rdChk

  task automatic busReset();
    @(posedge clk);
    busResetSeen <= 1'b1;
    @(posedge clk);
    busResetSeen <= 1'b0;
  endtask : busReset

  // Reset values, then FFh writes (BFh to index 1, 00h to 0 and 2) showing writable and constant bits.
  task automatic testBase();
    logic [7:0] rstExp [8];
    logic [7:0] wrVal  [8];
    logic [7:0] wrExp  [8];
    rstExp = '{8'hB5, 8'h3F, 8'hE3, 8'hEF, 8'h00, 8'h00, 8'hB0, 8'h00};
    wrVal  = '{8'h00, 8'hBF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    wrExp  = '{8'hB5, 8'hBF, 8'hE3, 8'hFF, 8'hC7, 8'hFF, 8'hBC, 8'hEF};
    for (int i = 0; i < 8; i++) rdChk(i[3:0], rstExp[i]);
    for (int i = 0; i < 8; i++) wr(i[3:0], wrVal[i]);
    for (int i = 0; i < 8; i++) rdChk(i[3:0], wrExp[i]);
    check({12'h000, rootHoldoffFlag, standbyRestoreAllow, linkActiveFlag, contenderFlag,
           powerClass, featureEnables, pageSelect, portSelect, gapCount},
          {12'h000, 4'hF, 3'h7, 8'hFF, 3'h7, 4'hF, 6'h3F});
  endtask : testBase

  // Every page in turn; pages 2 to 6 read zero and keep no data.
  task automatic testPages();
    for (int p = 0; p < 8; p++) begin
      wr(PPR_IDX_PAGE, {p[2:0], 5'h0F});
      wr(4'h8 + p[3:0], 8'hA0 + p[7:0]);
      rdChk(4'h8 + p[3:0], (p > 1 && p < 7) ? 8'h00 : 8'hA0 + p[7:0]);
      rdChk(PPR_IDX_EXT, 8'hE3);
      check({37'h0, pageSelect}, {37'h0, p[2:0]});
    end
    wr(PPR_IDX_PAGE, 8'h2F);
    rdChk(4'h9, 8'hA1);
    wr(PPR_IDX_PAGE, 8'h0F);
    rdChk(4'h9, 8'h00);
    rdChk(PPR_IDX_PAGED0, 8'hA0);
  endtask : testPages

  // Addresses outside the sixteen words are refused.
  task automatic testUnmapped();
    logic [31:0] d;
    logic        e;
    u_link.xfer(1'b0, 8'h40, 8'h00, d, e);
    check({7'h00, e, d}, {8'h01, 32'h0});
    u_link.xfer(1'b1, 8'h05, 8'h55, d, e);
    check({39'h0, e}, 40'h1);
    rdChk(PPR_IDX_GAP, 8'hBF);
  endtask : testUnmapped

  // Root flag set by tree identification and cleared by bus reset.
  task automatic testRoot();
    @(posedge clk);
    treeIdRoot <= 1'b1;
    @(posedge clk);
    treeIdRoot <= 1'b0;
    rdChk(PPR_IDX_NODE, 8'hB7);
    busReset();
    rdChk(PPR_IDX_NODE, 8'hB5);
  endtask : testRoot

  // Long reset waits for idle traffic, then lasts the set count.
  task automatic testLongReset();
    int n;
    trafficIdle <= 1'b0;
    wr(PPR_IDX_GAP, 8'h7F);
    rdChk(PPR_IDX_GAP, 8'h7F);
    n = 0;
    repeat (10) begin
      @(posedge clk);
      if (longResetActive !== 1'b0) n++;
    end
    check(40'(n), 40'h0);
    trafficIdle <= 1'b1;
    n = 0;
    while (longResetActive !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      errCount++;
      endSim();
    end
    n = 0;
    while (longResetActive === 1'b1 && n < 2 * LrCyc) begin
      @(posedge clk);
      n++;
    end
    check(40'(n), 40'(LrCyc));
    rdChk(PPR_IDX_GAP, 8'h3F);
    // With traffic already idle the drive starts on the third edge after the write.
    wr(PPR_IDX_GAP, 8'h7F);
    n = 0;
    while (longResetActive !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check(40'(n), 40'h3);
    n = 0;
    while (longResetActive === 1'b1 && n < 2 * LrCyc) begin
      @(posedge clk);
      n++;
    end
    check(40'(n), 40'(LrCyc));
  endtask : testLongReset

  // Gap count survives one reset after an update, reverts after two.
  task automatic testGap();
    wr(PPR_IDX_GAP, 8'h05);
    busReset();
    rdChk(PPR_IDX_GAP, 8'h05);
    @(posedge clk);
    configGapValue <= 6'h0A;
    configGapLoad  <= 1'b1;
    @(posedge clk);
    configGapLoad  <= 1'b0;
    busReset();
    rdChk(PPR_IDX_GAP, 8'h0A);
    busReset();
    rdChk(PPR_IDX_GAP, 8'h3F);
    check({34'h0, gapCount}, 40'h3F);
  endtask : testGap

  // Prints the verdict and stops the run.
  task automatic endSim();
    if (errCount == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : endSim

  // Main sequence: reset for eight cycles, then every scenario.
  initial begin
    errCount       = 0;
    nTests         = 0;
    srst           = 1'b1;
    nodeNumber     = 6'h2D;
    cablePowerOk   = 1'b1;
    treeIdRoot     = 1'b0;
    busResetSeen   = 1'b0;
    configGapLoad  = 1'b0;
    configGapValue = 6'h00;
    trafficIdle    = 1'b1;
    topLegacyRate  = 3'h5;
    betaLinkFlag   = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    testBase();
    testPages();
    testUnmapped();
    testRoot();
    testLongReset();
    testGap();
    endSim();
  end
endmodule : tb_top
`default_nettype wire
